// ==== verilog/async_serial_channel_pair.sv ====
// Asynchronous serial link built from a transmit and a receive channel.
// Assumes synchronous inputs, one clock, plain control and status ports.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_params.svh"

// Contract
// - Unit has four channels; link uses two
// - Seven or eight bits; nine on chosen instances
// - Send one or two stops; check one
// - Parity none, zero, even or odd
// - Software picks LSB or MSB first
// - Prescaler divides operating clock 1 to 2^15
// - Start trigger enables, stop halts, zero ignored
// - Mode bits 1 and 2 select async
// - Data write starts transmission when enabled
// - Receiver starts only on start bit
// - Flag overrun, parity and framing errors
// - Separate transmit, receive, empty, error interrupts
// - Single mode: interrupt after last stop
// - Continuous mode: interrupt on shift load
// - Receive interrupt on stop, even with errors
// - Interrupt on overrun of unread character
// - Even channel transmits, odd channel receives
// - Upper seven data bits hold divisor
// - Clear triggers reset the error flags
module async_serial_channel_pair #(
	parameter bit NINE_BIT_EN = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] start_trigger_i,
	input wire logic [1:0] stop_trigger_i,
	input wire logic [2:0] op_mode_i,
	input wire async_serial_pkg::cfg_t cfg_i,
	input wire logic [`DATA_W-1:0] tx_data_i,
	input wire logic tx_write_i,
	output logic tx_ready_o,
	output logic tx_line_o,
	input wire logic rx_line_i,
	output logic [`DATA_W-1:0] rx_data_o,
	output logic rx_full_o,
	input wire logic rx_read_i,
	input wire async_serial_pkg::err_flags_t err_clear_i,
	output async_serial_pkg::err_flags_t err_flags_o,
	output logic [1:0] chan_en_o,
	output logic tx_busy_o,
	output logic tx_irq_o,
	output logic rx_irq_o,
	output logic buf_empty_irq_o,
	output logic err_irq_o
);

	async_serial_pkg::tx_state_t tx_state_ff, nxt_tx_state;
	async_serial_pkg::rx_state_t rx_state_ff, nxt_rx_state;
	logic [1:0] nxt_chan_en;
	logic async_sel, tx_act, rx_act, tick;
	logic [3:0] nbits;
	logic [`BCNT_W-1:0] bit_last, half_last;
	logic [`BCNT_W-1:0] tbcnt_ff, nxt_tbcnt, rbcnt_ff, nxt_rbcnt;
	logic [`IDX_W-1:0] tidx_ff, nxt_tidx, ridx_ff, nxt_ridx, first_idx;
	logic [`DATA_W-1:0] tsh_ff, nxt_tsh, rsh_ff, nxt_rsh, nxt_rx_data;
	logic nxt_txd, nxt_tx_irq, nxt_be_irq, nxt_busy, tbit_end, tlast;
	logic rbit_end, rhalf, rlast, rx_done, nxt_rx_full, nxt_rx_irq;
	logic pbad_ff, nxt_pbad, nxt_err_irq;
	async_serial_pkg::err_flags_t err_set, nxt_err;
	logic fifo_valid, fifo_pop;
	logic [`DATA_W-1:0] fifo_data;

	// Character width, nine bits only where the instance allows it
	function automatic logic [3:0] char_bits(input logic [1:0] len);
		logic [3:0] n;
		n = 4'h8;
		if (len == `CHAR_7) begin
			n = 4'h7;
		end else if (len == `CHAR_9 && NINE_BIT_EN) begin
			n = 4'h9;
		end
		return n;
	endfunction

	// Parity bit over the active character bits
	function automatic logic par_bit(input logic [`DATA_W-1:0] d,
		input logic [3:0] n, input logic [1:0] mode);
		logic x;
		x = ^(d & (9'h1FF >> (4'h9 - n)));
		case (mode)
			`PAR_EVEN: par_bit = x;
			`PAR_ODD: par_bit = ~x;
			default: par_bit = 1'b0;
		endcase
	endfunction

	// Mode decode and bit timing
	always_comb begin
		async_sel = (op_mode_i[2:1] == `MODE_ASYNC);
		tx_act = chan_en_o[`CHAN_TX] & async_sel;
		rx_act = chan_en_o[`CHAN_RX] & async_sel;
		nbits = char_bits(cfg_i.char_len);
		bit_last = {cfg_i.baud_div, 1'b1};
		half_last = {1'b0, cfg_i.baud_div};
		first_idx = cfg_i.msb_first ? nbits - 4'h1 : 4'h0;
	end

	// Transfer clock shared by both channels
	tick_prescaler u_presc (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(tx_act | rx_act),
		.exp_i(cfg_i.presc_exp),
		.tick_o(tick)
	);

	// Transmit data buffer; writes only land while the channel runs
	sync_fifo #(.W(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(tx_write_i & tx_act),
		.in_ready_o(tx_ready_o),
		.in_data_i(tx_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	// Per-channel enable: start sets, stop clears and wins
	always_comb begin
		nxt_chan_en = (chan_en_o | start_trigger_i) & ~stop_trigger_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chan_en_o <= 2'h0;
		end else begin
			chan_en_o <= nxt_chan_en;
		end
	end

	// Transmit sequencer
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tbcnt = tbcnt_ff;
		nxt_tidx = tidx_ff;
		nxt_tsh = tsh_ff;
		nxt_tx_irq = 1'b0;
		nxt_be_irq = 1'b0;
		fifo_pop = 1'b0;
		tbit_end = tick & (tbcnt_ff == bit_last);
		tlast = cfg_i.msb_first ? (tidx_ff == 4'h0) : (tidx_ff == nbits - 4'h1);
		if (tick) begin
			nxt_tbcnt = tbit_end ? '0 : tbcnt_ff + `BCNT_W'(1);
		end
		unique case (tx_state_ff)
			async_serial_pkg::TX_IDLE: begin
				nxt_tbcnt = '0;
				if (tx_act && fifo_valid) begin
					fifo_pop = 1'b1;
					nxt_tsh = fifo_data;
					nxt_tx_state = async_serial_pkg::TX_START;
					nxt_be_irq = 1'b1;
					nxt_tx_irq = cfg_i.cont_mode;
				end
			end
			async_serial_pkg::TX_START: begin
				if (tbit_end) begin
					nxt_tx_state = async_serial_pkg::TX_DATA;
					nxt_tidx = first_idx;
				end
			end
			async_serial_pkg::TX_DATA: begin
				if (tbit_end && tlast) begin
					nxt_tidx = 4'h0;
					if (cfg_i.parity == `PAR_NONE) begin
						nxt_tx_state = async_serial_pkg::TX_STOP;
					end else begin
						nxt_tx_state = async_serial_pkg::TX_PAR;
					end
				end else if (tbit_end) begin
					nxt_tidx = cfg_i.msb_first ? tidx_ff - 4'h1 : tidx_ff + 4'h1;
				end
			end
			async_serial_pkg::TX_PAR: begin
				if (tbit_end) begin
					nxt_tx_state = async_serial_pkg::TX_STOP;
				end
			end
			async_serial_pkg::TX_STOP: begin
				if (tbit_end && cfg_i.two_stop && tidx_ff == 4'h0) begin
					nxt_tidx = 4'h1;
				end else if (tbit_end) begin
					nxt_tx_state = async_serial_pkg::TX_IDLE;
					nxt_tx_irq = ~cfg_i.cont_mode;
				end
			end
			default: begin
				nxt_tx_state = async_serial_pkg::TX_IDLE;
			end
		endcase
		// Stopping the channel abandons any character in flight
		if (!tx_act) begin
			nxt_tx_state = async_serial_pkg::TX_IDLE;
			nxt_tbcnt = '0;
		end
		// Line level follows the next state
		unique case (nxt_tx_state)
			async_serial_pkg::TX_START: nxt_txd = 1'b0;
			async_serial_pkg::TX_DATA: nxt_txd = nxt_tsh[nxt_tidx];
			async_serial_pkg::TX_PAR: nxt_txd = par_bit(nxt_tsh, nbits,
				cfg_i.parity);
			default: nxt_txd = `LINE_IDLE;
		endcase
		nxt_busy = (nxt_tx_state != async_serial_pkg::TX_IDLE);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_state_ff <= async_serial_pkg::TX_IDLE;
			tbcnt_ff <= '0;
			tidx_ff <= '0;
			tsh_ff <= '0;
			tx_line_o <= `LINE_IDLE;
			tx_busy_o <= 1'b0;
			tx_irq_o <= 1'b0;
			buf_empty_irq_o <= 1'b0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tbcnt_ff <= nxt_tbcnt;
			tidx_ff <= nxt_tidx;
			tsh_ff <= nxt_tsh;
			tx_line_o <= nxt_txd;
			tx_busy_o <= nxt_busy;
			tx_irq_o <= nxt_tx_irq;
			buf_empty_irq_o <= nxt_be_irq;
		end
	end

	// Receive sequencer, sampling at mid-bit
	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rbcnt = rbcnt_ff;
		nxt_ridx = ridx_ff;
		nxt_rsh = rsh_ff;
		nxt_pbad = pbad_ff;
		rx_done = 1'b0;
		err_set = '0;
		rbit_end = tick & (rbcnt_ff == bit_last);
		rhalf = tick & (rbcnt_ff == half_last);
		rlast = cfg_i.msb_first ? (ridx_ff == 4'h0) : (ridx_ff == nbits - 4'h1);
		if (tick) begin
			nxt_rbcnt = rbit_end ? '0 : rbcnt_ff + `BCNT_W'(1);
		end
		unique case (rx_state_ff)
			async_serial_pkg::RX_IDLE: begin
				nxt_rbcnt = '0;
				if (rx_act && !rx_line_i) begin
					nxt_rx_state = async_serial_pkg::RX_START;
				end
			end
			async_serial_pkg::RX_START: begin
				if (rhalf) begin
					nxt_rbcnt = '0;
					nxt_rsh = '0;
					nxt_pbad = 1'b0;
					nxt_ridx = first_idx;
					// A glitch shorter than half a bit is no start bit
					nxt_rx_state = rx_line_i ? async_serial_pkg::RX_IDLE :
						async_serial_pkg::RX_DATA;
				end
			end
			async_serial_pkg::RX_DATA: begin
				if (rbit_end) begin
					nxt_rsh[ridx_ff] = rx_line_i;
					nxt_ridx = cfg_i.msb_first ? ridx_ff - 4'h1 : ridx_ff + 4'h1;
					if (rlast && cfg_i.parity == `PAR_NONE) begin
						nxt_rx_state = async_serial_pkg::RX_STOP;
					end else if (rlast) begin
						nxt_rx_state = async_serial_pkg::RX_PAR;
					end
				end
			end
			async_serial_pkg::RX_PAR: begin
				if (rbit_end) begin
					nxt_pbad = rx_line_i != par_bit(rsh_ff, nbits,
						cfg_i.parity);
					nxt_rx_state = async_serial_pkg::RX_STOP;
				end
			end
			async_serial_pkg::RX_STOP: begin
				// One stop bit is checked whatever the transmit setting
				if (rbit_end) begin
					rx_done = 1'b1;
					err_set.framing = ~rx_line_i;
					err_set.parity = pbad_ff;
					err_set.overrun = rx_full_o & ~rx_read_i;
					nxt_rx_state = async_serial_pkg::RX_IDLE;
				end
			end
			default: begin
				nxt_rx_state = async_serial_pkg::RX_IDLE;
			end
		endcase
		if (!rx_act) begin
			nxt_rx_state = async_serial_pkg::RX_IDLE;
			nxt_rbcnt = '0;
		end
		// Completion pulse comes even with a bad character
		nxt_rx_irq = rx_done;
		nxt_rx_data = rx_done ? rsh_ff : rx_data_o;
		nxt_rx_full = (rx_full_o & ~rx_read_i) | rx_done;
		// New error outranks a clear in the same cycle
		nxt_err = (err_flags_o & ~err_clear_i) | err_set;
		nxt_err_irq = |err_set;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_state_ff <= async_serial_pkg::RX_IDLE;
			rbcnt_ff <= '0;
			ridx_ff <= '0;
			rsh_ff <= '0;
			pbad_ff <= 1'b0;
			rx_data_o <= '0;
			rx_full_o <= 1'b0;
			rx_irq_o <= 1'b0;
			err_flags_o <= '0;
			err_irq_o <= 1'b0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rbcnt_ff <= nxt_rbcnt;
			ridx_ff <= nxt_ridx;
			rsh_ff <= nxt_rsh;
			pbad_ff <= nxt_pbad;
			rx_data_o <= nxt_rx_data;
			rx_full_o <= nxt_rx_full;
			rx_irq_o <= nxt_rx_irq;
			err_flags_o <= nxt_err;
			err_irq_o <= nxt_err_irq;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/async_serial_params.svh ====
// Constants for the paired-channel asynchronous serial link.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ASYNC_SERIAL_PARAMS_SVH
`define ASYNC_SERIAL_PARAMS_SVH

// Channels per serial unit; a link uses two of them
`define UNIT_CHANNELS 4
`define CHAN_TX 0
`define CHAN_RX 1

// Upper and middle mode bits that select asynchronous operation
`define MODE_ASYNC 2'h1

// Widths
`define DATA_W 9
`define DIV_W 7
`define PRESC_EXP_W 4
`define PRESC_CNT_W 15
`define BCNT_W 8
`define IDX_W 4

// Character length codes
`define CHAR_7 2'h0
`define CHAR_8 2'h1
`define CHAR_9 2'h2

// Parity codes
`define PAR_NONE 2'h0
`define PAR_ZERO 2'h1
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3

// Transmit buffer
`define FIFO_DEPTH 4
`define FIFO_AW 2

// Resting level of the transmit line
`define LINE_IDLE 1'b1

`endif

// ==== verilog/async_serial_pkg.sv ====
// Types shared by the serial link modules.
// Assumes the constants header is on the include path.
`include "async_serial_params.svh"

package async_serial_pkg;

	// Link configuration carried as one bundle
	typedef struct packed {
		logic [1:0] char_len;
		logic two_stop;
		logic [1:0] parity;
		logic msb_first;
		logic cont_mode;
		logic [`DIV_W-1:0] baud_div;
		logic [`PRESC_EXP_W-1:0] presc_exp;
	} cfg_t;

	// Receive error flags
	typedef struct packed {
		logic overrun;
		logic parity;
		logic framing;
	} err_flags_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h2,
		TX_PAR = 3'h3,
		TX_STOP = 3'h4
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_PAR = 3'h3,
		RX_STOP = 3'h4
	} rx_state_t;

endpackage

// ==== verilog/sync_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign out_data_o = mem_ff[rd_ptr_ff];

	// Pointer and fill-level update
	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// Registered flags keep full and empty glitch free
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
			in_ready_o <= (nxt_cnt != (AW+1)'(DEPTH));
			out_valid_o <= (nxt_cnt != '0);
		end
	end

	// Storage, written only on accepted pushes
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/tick_prescaler.sv ====
// Power-of-two prescaler producing the transfer clock tick.
// Assumes the operating clock on clk_i; tick is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_params.svh"

module tick_prescaler (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	input wire logic [`PRESC_EXP_W-1:0] exp_i,
	output logic tick_o
);

	logic [`PRESC_CNT_W-1:0] cnt_ff, nxt_cnt, limit;
	logic nxt_tick;

	// Divide by 2^exp, 1 to 2^15; restart at once if the limit drops
	always_comb begin
		limit = (`PRESC_CNT_W'(1) << exp_i) - `PRESC_CNT_W'(1);
		nxt_tick = en_i & (cnt_ff >= limit);
		if (!en_i || cnt_ff >= limit) begin
			nxt_cnt = '0;
		end else begin
			nxt_cnt = cnt_ff + `PRESC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_o <= nxt_tick;
		end
	end

endmodule

`default_nettype wire

// ==== sim/async_serial_channel_pair_asserts.sv ====
// Port checker for the paired serial link.
// Assumes binding onto the top module; one clock, reset low.
`timescale 1ns/1ps
`default_nettype none
module async_serial_channel_pair_asserts (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] start_trigger_i,
	input wire logic [1:0] stop_trigger_i,
	input wire logic [2:0] op_mode_i,
	input wire async_serial_pkg::cfg_t cfg_i,
	input wire logic tx_write_i,
	input wire logic tx_ready_o,
	input wire logic tx_line_o,
	input wire logic rx_full_o,
	input wire logic rx_read_i,
	input wire async_serial_pkg::err_flags_t err_flags_o,
	input wire logic [1:0] chan_en_o,
	input wire logic tx_busy_o,
	input wire logic tx_irq_o,
	input wire logic rx_irq_o,
	input wire logic buf_empty_irq_o,
	input wire logic err_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Accepted start request, accepted write, first start bit
	sequence s_go;
		start_trigger_i[0] && !stop_trigger_i[0];
	endsequence
	sequence s_wr;
		tx_write_i && tx_ready_o && chan_en_o[0] && op_mode_i[2:1] == 2'h1;
	endsequence
	sequence s_load;
		##[1:3] (buf_empty_irq_o && !tx_line_o);
	endsequence
	AST_GO: assert property (s_go |=> chan_en_o[0])
		else $error("tx channel not enabled");
	AST_HALT: assert property (stop_trigger_i[0] |=> !chan_en_o[0])
		else $error("tx channel not halted");
	AST_START: assert property (s_wr ##0 !tx_busy_o |-> s_load)
		else $error("write did not start a frame");
	AST_IDLE: assert property (!tx_busy_o |-> tx_line_o)
		else $error("tx line low while idle");
	AST_CONT: assert property (
		buf_empty_irq_o && cfg_i.cont_mode |-> tx_irq_o)
		else $error("no tx pulse on load");
	AST_SINGLE: assert property (
		tx_irq_o && !cfg_i.cont_mode |-> tx_line_o && !tx_busy_o)
		else $error("tx pulse before frame end");
	AST_RXF: assert property (rx_irq_o |-> rx_full_o)
		else $error("rx pulse without data");
	AST_ERRI: assert property (err_irq_o |-> err_flags_o != 3'h0)
		else $error("error pulse without flag");
	AST_OVR: assert property (
		rx_irq_o && $past(rx_full_o) && !$past(rx_read_i) |->
		err_flags_o.overrun)
		else $error("overrun not flagged");
endmodule
bind async_serial_channel_pair async_serial_channel_pair_asserts chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .start_trigger_i(start_trigger_i),
	.stop_trigger_i(stop_trigger_i), .op_mode_i(op_mode_i), .cfg_i(cfg_i),
	.tx_write_i(tx_write_i), .tx_ready_o(tx_ready_o), .tx_line_o(tx_line_o),
	.rx_full_o(rx_full_o), .rx_read_i(rx_read_i), .err_flags_o(err_flags_o),
	.chan_en_o(chan_en_o), .tx_busy_o(tx_busy_o), .tx_irq_o(tx_irq_o),
	.rx_irq_o(rx_irq_o), .buf_empty_irq_o(buf_empty_irq_o),
	.err_irq_o(err_irq_o)
);
`default_nettype wire

// ==== sim/serial_peer.sv ====
// Far-end serial peer: drives the link's receive line, samples its
// transmit line. Assumes BIT_CLKS operating clocks per bit.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_params.svh"
module serial_peer #(
	parameter int BIT_CLKS = 4
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	// Line rests at mark between frames
	initial line_o = 1'b1;
	// Frame from bit 0: start, data, parity, stops; bad flips parity
	// (bit 0) or zeroes the stop bit (bit 1)
	function automatic logic [12:0] build(logic [8:0] d, int n,
		logic [1:0] pm, logic msb, logic [1:0] bad);
		logic [12:0] f;
		logic x;
		f = '1;
		f[0] = 1'b0;
		x = 1'b0;
		for (int k = 0; k < n; k++) begin
			f[k+1] = msb ? d[n-1-k] : d[k];
			x ^= d[k];
		end
		if (pm == `PAR_ODD) x = !x;
		if (pm == `PAR_ZERO) x = 1'b0;
		if (pm != `PAR_NONE) f[n+1] = x ^ bad[0];
		f[n + 1 + int'(pm != `PAR_NONE)] = !bad[1];
		return f;
	endfunction
	// Shifts nb bits out, one per bit time
	task automatic send(logic [12:0] f, int nb);
		for (int i = 0; i < nb; i++) begin
			line_o = f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
			#1;
		end
		line_o = 1'b1;
	endtask
	// Waits for a start bit, samples nb bits at mid-bit
	task automatic grab(int nb, output logic [12:0] f, output bit hit);
		f = '1;
		hit = 1'b0;
		for (int w = 0; w < 4000 && !hit; w++) begin
			@(posedge clk_i);
			#1;
			hit = !line_i;
		end
		// Sample a settled line, half a bit into each bit
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		#1;
		for (int i = 0; i < nb; i++) begin
			f[i] = line_i;
			if (i < nb - 1) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				#1;
			end
		end
	endtask
endmodule
`default_nettype wire

// ==== sim/async_serial_channel_pair_tb.sv ====
// Bench for the serial link against the far-end peer.
// Assumes prescale 1 and divisor 1: four clocks per bit.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_params.svh"
module async_serial_channel_pair_tb;
	typedef struct {
		logic [1:0] len;
		logic two;
		logic [1:0] pm;
		logic msb;
		logic [8:0] d;
	} row_t;
	// Every length, parity code, stop count and bit order
	row_t rows[6] = '{
		'{`CHAR_7, 1'b0, `PAR_NONE, 1'b0, 9'h1D5},
		'{`CHAR_8, 1'b1, `PAR_ZERO, 1'b1, 9'h0A3},
		'{`CHAR_9, 1'b0, `PAR_EVEN, 1'b0, 9'h1C5},
		'{`CHAR_8, 1'b0, `PAR_ODD, 1'b1, 9'h07E},
		'{`CHAR_7, 1'b1, `PAR_EVEN, 1'b1, 9'h06B},
		'{`CHAR_9, 1'b1, `PAR_ODD, 1'b0, 9'h13A}
	};
	logic clk_i, rst_b_i, tx_write, tx_ready, tx_line, rx_line, rx_full;
	logic rx_read, tx_busy, tx_irq, rx_irq, be_irq, err_irq, prev_line;
	logic [1:0] go_trig, halt_trig, chan_en;
	logic [2:0] op_mode;
	logic [8:0] tx_data, rx_data;
	logic [12:0] f, ef;
	async_serial_pkg::cfg_t cfg;
	async_serial_pkg::err_flags_t err_clear, err_flags;
	bit hit;
	int mismatches = 0, n_tests = 0, tx_n = 0, rx_n = 0, be_n = 0, er_n = 0;
	int n, nb, k0, k1;
	async_serial_channel_pair dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.start_trigger_i(go_trig), .stop_trigger_i(halt_trig),
		.op_mode_i(op_mode), .cfg_i(cfg), .tx_data_i(tx_data),
		.tx_write_i(tx_write), .tx_ready_o(tx_ready), .tx_line_o(tx_line),
		.rx_line_i(rx_line), .rx_data_o(rx_data), .rx_full_o(rx_full),
		.rx_read_i(rx_read), .err_clear_i(err_clear), .err_flags_o(err_flags),
		.chan_en_o(chan_en), .tx_busy_o(tx_busy), .tx_irq_o(tx_irq),
		.rx_irq_o(rx_irq), .buf_empty_irq_o(be_irq), .err_irq_o(err_irq));
	serial_peer peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Pulse counters, sampled mid-cycle where pulses are settled
	always @(negedge clk_i) begin
		tx_n += int'(tx_irq === 1'b1);
		rx_n += int'(rx_irq === 1'b1);
		be_n += int'(be_irq === 1'b1);
		er_n += int'(err_irq === 1'b1);
	end
	task automatic check(string what, logic [12:0] got, logic [12:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic step(int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	// Write strobe stays up; caller lowers it
	task automatic put(logic [8:0] d);
		tx_data = d;
		tx_write = 1'b1;
		step(1);
	endtask
	task automatic take(int bits);
		peer.grab(bits, f, hit);
		if (!hit) begin
			mismatches++;
			summarize();
		end
	endtask
	initial begin
		rst_b_i = 1'b0;
		go_trig = 2'h0;
		halt_trig = 2'h0;
		op_mode = 3'h2;
		cfg = '0;
		cfg.baud_div = 7'h01;
		tx_data = 9'h000;
		tx_write = 1'b0;
		rx_read = 1'b0;
		err_clear = '0;
		step(10);
		rst_b_i = 1'b1;
		check("reset", 13'({tx_line, chan_en}), 13'h0004);
		// Write to a stopped channel is dropped
		put(9'h0AA);
		tx_write = 1'b0;
		step(4);
		check("busy_off", 13'(tx_busy), 13'h0000);
		go_trig = 2'h3;
		step(1);
		go_trig = 2'h0;
		check("chan_en", 13'(chan_en), 13'h0003);
		// Mode bits 10 are not asynchronous
		op_mode = 3'h4;
		put(9'h0AA);
		tx_write = 1'b0;
		step(4);
		check("busy_mode", 13'(tx_busy), 13'h0000);
		op_mode = 3'h3;
		foreach (rows[i]) begin
			cfg.char_len = rows[i].len;
			cfg.two_stop = rows[i].two;
			cfg.parity = rows[i].pm;
			cfg.msb_first = rows[i].msb;
			n = 7 + int'(rows[i].len);
			nb = n + 2 + int'(rows[i].pm != `PAR_NONE);
			ef = peer.build(rows[i].d, n, rows[i].pm, rows[i].msb, 2'h0);
			k0 = tx_n;
			put(rows[i].d);
			tx_write = 1'b0;
			take(nb + int'(rows[i].two));
			check("tx_frame", f, ef);
			step(6);
			check("tx_irq", 13'(tx_n - k0), 13'h0001);
			k0 = rx_n;
			peer.send(ef, nb);
			step(2);
			check("rx_data", 13'(rx_data), 13'(rows[i].d & (9'h1FF >> (9 - n))));
			check("rx_flags", 13'({rx_full, err_flags}), 13'h0008);
			check("rx_irq", 13'(rx_n - k0), 13'h0001);
			rx_read = 1'b1;
			step(1);
			rx_read = 1'b0;
		end
		// Five back-to-back writes fill the buffer; a sixth is refused
		cfg.char_len = `CHAR_8;
		cfg.parity = `PAR_NONE;
		cfg.two_stop = 1'b0;
		cfg.msb_first = 1'b0;
		cfg.cont_mode = 1'b1;
		k0 = be_n;
		k1 = tx_n;
		// First frame starts while writes go on: watch the line meanwhile
		fork
			begin
				for (int i = 0; i < 5; i++) put(9'(i * 17));
				check("tx_ready", 13'(tx_ready), 13'h0000);
				put(9'h1FF);
				tx_write = 1'b0;
			end
			for (int i = 0; i < 5; i++) begin
				take(10);
				check("fifo", f, peer.build(9'(i * 17), 8, 2'h0, 1'b0, 2'h0));
			end
		join
		step(20);
		check("busy_end", 13'(tx_busy), 13'h0000);
		check("be_irq", 13'(be_n - k0), 13'h0005);
		check("tx_irq_c", 13'(tx_n - k1), 13'h0005);
		cfg.cont_mode = 1'b0;
		// Prescale by two: 4 ticks of 2 clocks per bit, so bits 4..7 of
		// 00F hold the line low for 32 clocks
		cfg.presc_exp = 4'h1;
		put(9'h00F);
		tx_write = 1'b0;
		prev_line = 1'b1;
		k0 = 0;
		k1 = 0;
		for (int i = 0; i < 120; i++) begin
			step(1);
			if (tx_line === 1'b1 && prev_line === 1'b0) begin
				k0++;
			end
			if (k0 == 1 && tx_line === 1'b0) begin
				k1++;
			end
			prev_line = tx_line;
		end
		check("presc", 13'(k1), 13'h0020);
		cfg.presc_exp = 4'h0;
		// Halting mid-frame returns the line to mark
		put(9'h000);
		tx_write = 1'b0;
		step(8);
		halt_trig = 2'h1;
		step(1);
		halt_trig = 2'h0;
		step(1);
		check("halt", 13'({chan_en[0], tx_line}), 13'h0001);
		// One-clock low pulse is no start bit
		k0 = rx_n;
		peer.line_o = 1'b0;
		step(1);
		peer.line_o = 1'b1;
		step(12);
		check("glitch", 13'(rx_n - k0), 13'h0000);
		// Parity error, then framing error and overrun without a read
		cfg.parity = `PAR_EVEN;
		k0 = rx_n;
		k1 = er_n;
		peer.send(peer.build(9'h05A, 8, `PAR_EVEN, 1'b0, 2'h1), 11);
		step(2);
		check("par_err", 13'(err_flags), 13'h0002);
		peer.send(peer.build(9'h05A, 8, `PAR_EVEN, 1'b0, 2'h2), 11);
		step(2);
		check("frm_ovr", 13'(err_flags), 13'h0007);
		check("rx_irq_e", 13'(rx_n - k0), 13'h0002);
		check("err_irq", 13'(er_n - k1), 13'h0002);
		err_clear = 3'h7;
		rx_read = 1'b1;
		step(1);
		err_clear = 3'h0;
		rx_read = 1'b0;
		check("cleared", 13'({rx_full, err_flags}), 13'h0000);
		summarize();
	end
endmodule
`default_nettype wire
